// ===== frc_ctrl.sv
// Purpose: apb register bank steering the fixed reference and temperature indicator
// Assumes: analog side gives a raw stabilisation-complete level from its own domain
// Notes: zero wait states, unmapped addresses read zero and flag pslverr
`include "frc_regs.svh"

module frc_ctrl #(
	parameter bit HIGH_VOLTAGE = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic analog_stable,
	output logic reference_enable,
	output logic temp_sense_enable,
	output logic temp_range_select,
	output frc_pkg::frc_gain_t comparator_path_gain,
	output frc_pkg::frc_gain_t converter_path_gain,
	output logic comparator_buf_on,
	output logic converter_buf_on,
	output logic temp_to_converter,
	output logic [4:0] temp_channel,
	output logic buffers_settled
);
	import frc_pkg::*;

	logic [7:0] ctrl_q; // writable control bits
	logic stable_s1_q; // synchroniser first stage
	logic stable_s2_q; // synchroniser second stage
	frc_state_t state_q; // reference startup state
	logic ready_q; // ready flag
	logic wr_ctrl; // write to control this cycle
	logic access; // apb access phase
	logic mapped; // address hits a register
	logic [1:0] cmp_gain_prev_q; // previous comparator gain
	logic [1:0] cnv_gain_prev_q; // previous converter gain
	logic buf_restart; // a buffer just switched on
	logic settled; // settle timer done

	assign access = psel && penable;
	assign mapped = (paddr == `FRC_CTRL_OFFSET) || (paddr == `FRC_STAT_OFFSET);
	assign wr_ctrl = access && pwrite && (paddr == `FRC_CTRL_OFFSET);

	// control register write, ready bit masked off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `FRC_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata[7:0] & `FRC_CTRL_WMASK;
		end
	end

	// two-flop sync of the analog stable level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_s1_q <= 1'b0;
			stable_s2_q <= 1'b0;
		end else begin
			stable_s1_q <= analog_stable;
			stable_s2_q <= stable_s1_q;
		end
	end

	// startup sequence: off, waiting, ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= FRC_ST_OFF;
		end else begin
			case (state_q)
				FRC_ST_OFF: begin
					if (ctrl_q[`FRC_BIT_ENABLE]) begin
						state_q <= FRC_ST_WAIT;
					end
				end
				FRC_ST_WAIT: begin
					if (!ctrl_q[7]) begin
						state_q <= FRC_ST_OFF;
					end else if (stable_s2_q) begin
						state_q <= FRC_ST_READY;
					end
				end
				FRC_ST_READY: begin
					if (!ctrl_q[7] || !stable_s2_q) begin
						state_q <= FRC_ST_OFF;
					end
				end
				default: begin
					state_q <= FRC_ST_OFF;
				end
			endcase
		end
	end

	// ready flag: forced one on high-voltage variant, else gated by enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= HIGH_VOLTAGE;
		end else if (HIGH_VOLTAGE) begin
			ready_q <= 1'b1;
		end else begin
			ready_q <= ctrl_q[7] && stable_s2_q && (state_q != FRC_ST_OFF);
		end
	end

	// analog control outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reference_enable <= 1'b0;
			temp_sense_enable <= 1'b0;
			temp_range_select <= 1'b0;
			comparator_path_gain <= FRC_GAIN_OFF_E;
			converter_path_gain <= FRC_GAIN_OFF_E;
			comparator_buf_on <= 1'b0;
			converter_buf_on <= 1'b0;
			temp_to_converter <= 1'b0;
			temp_channel <= `FRC_TEMP_CHANNEL;
		end else begin
			reference_enable <= ctrl_q[7];
			temp_sense_enable <= ctrl_q[`FRC_BIT_TS_EN];
			temp_range_select <= ctrl_q[`FRC_BIT_TS_RNG];
			comparator_path_gain <= frc_gain_t'(ctrl_q[3:2]);
			converter_path_gain <= frc_gain_t'(ctrl_q[1:0]);
			comparator_buf_on <= ctrl_q[3:2] != `FRC_GAIN_OFF;
			converter_buf_on <= ctrl_q[1:0] != `FRC_GAIN_OFF;
			temp_to_converter <= ctrl_q[`FRC_BIT_TS_EN];
			temp_channel <= `FRC_TEMP_CHANNEL;
		end
	end

	// watch buffers turning on to restart the settle window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_gain_prev_q <= 2'h0;
			cnv_gain_prev_q <= 2'h0;
		end else begin
			cmp_gain_prev_q <= ctrl_q[3:2];
			cnv_gain_prev_q <= ctrl_q[1:0];
		end
	end
	assign buf_restart = ((cmp_gain_prev_q == 2'h0) && (ctrl_q[3:2] != 2'h0))
		|| ((cnv_gain_prev_q == 2'h0) && (ctrl_q[1:0] != 2'h0));

	// settle window a buffer needs after switch-on
	frc_settle_timer #(
		.CYCLES(`FRC_BUF_SETTLE_CYC)
	) u_settle (
		.pclk(pclk),
		.presetn(presetn),
		.restart(buf_restart),
		.done(settled)
	);

	// status copy of the settle window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffers_settled <= 1'b1;
		end else begin
			buffers_settled <= settled;
		end
	end

	// apb answer: zero wait, registered read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				if (paddr == `FRC_CTRL_OFFSET) begin
					prdata <= {24'h000000, ctrl_q[7], ready_q, ctrl_q[5:0]};
				end else if (paddr == `FRC_STAT_OFFSET) begin
					prdata <= {30'h0000_0000, settled, ready_q};
				end
			end
		end
	end

	// enable bit low clears the ready flag next cycle, except on the high-voltage variant
	property p_disable_drops_ready;
		@(posedge pclk) disable iff (!presetn)
		(!HIGH_VOLTAGE && !ctrl_q[7]) |=> !ready_q;
	endproperty
	a_disable_drops_ready: assert property (p_disable_drops_ready) else $error("ready high while off");

	property p_hv_ready;
		@(posedge pclk) disable iff (!presetn)
		HIGH_VOLTAGE |-> ready_q;
	endproperty
	a_hv_ready: assert property (p_hv_ready) else $error("ready low on hv variant");

	property p_enable_write;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> ##1 (reference_enable == $past(pwdata[7], 2));
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable did not follow write");

	property p_ready_needs_stable;
		@(posedge pclk) disable iff (!presetn)
		(!HIGH_VOLTAGE && $rose(ready_q)) |-> $past(stable_s2_q);
	endproperty
	a_ready_needs_stable: assert property (p_ready_needs_stable) else $error("ready before stable");

	property p_ts_enable;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> ##1 (temp_sense_enable == $past(pwdata[5], 2));
	endproperty
	a_ts_enable: assert property (p_ts_enable) else $error("sense enable mismatch");

	property p_ts_range;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> ##1 (temp_range_select == $past(pwdata[4], 2));
	endproperty
	a_ts_range: assert property (p_ts_range) else $error("range select mismatch");

	property p_cmp_gain;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> ##1 (comparator_buf_on == ($past(pwdata[3:2], 2) != 2'h0));
	endproperty
	a_cmp_gain: assert property (p_cmp_gain) else $error("comparator buffer state wrong");

	property p_cnv_gain;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> ##1 (converter_path_gain == frc_gain_t'($past(pwdata[1:0], 2)));
	endproperty
	a_cnv_gain: assert property (p_cnv_gain) else $error("converter gain wrong");

	property p_reset_clear;
		@(posedge pclk) $rose(presetn) |-> (ctrl_q == 8'h00);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("control not cleared by reset");

	property p_ready_reads_low_off;
		@(posedge pclk) disable iff (!presetn)
		(!HIGH_VOLTAGE && state_q == FRC_ST_OFF) |-> ##1 !ready_q;
	endproperty
	a_ready_reads_low_off: assert property (p_ready_reads_low_off) else $error("ready while off");
endmodule

// ===== frc_regs.svh
// Purpose: constants for the fixed reference control register bank
// Assumes: apb byte addresses, 32-bit data, 25 MHz pclk
// Notes: 8-bit control register and 2-bit status register, each in the low bits of its word
`ifndef FRC_REGS_SVH
`define FRC_REGS_SVH
// register byte addresses
`define FRC_CTRL_OFFSET 12'h000
`define FRC_STAT_OFFSET 12'h004
// reference control field positions
`define FRC_BIT_ENABLE 7
`define FRC_BIT_READY 6
`define FRC_BIT_TS_EN 5
`define FRC_BIT_TS_RNG 4
`define FRC_CTRL_RESET 8'h00
// writable bit mask (ready flag is read-only)
`define FRC_CTRL_WMASK 8'hBF
// gain field codes
`define FRC_GAIN_OFF 2'h0
`define FRC_GAIN_X1 2'h1
`define FRC_GAIN_X2 2'h2
`define FRC_GAIN_X4 2'h3
// reserved converter channel for the temperature indicator
`define FRC_TEMP_CHANNEL 5'h1D
// acquisition wait and buffer settle, in ns, and cycle counts
`define FRC_CLK_PERIOD_NS 40
`define FRC_TEMP_ACQ_NS 200000
`define FRC_BUF_SETTLE_NS 30000
`define FRC_TEMP_ACQ_CYC ((`FRC_TEMP_ACQ_NS + `FRC_CLK_PERIOD_NS - 1) / `FRC_CLK_PERIOD_NS)
`define FRC_BUF_SETTLE_CYC ((`FRC_BUF_SETTLE_NS + `FRC_CLK_PERIOD_NS - 1) / `FRC_CLK_PERIOD_NS)
`endif

// ===== frc_pkg.sv
// Purpose: types for the fixed reference control block
// Assumes: nothing beyond the constants header
// Notes: gain decode shared by both buffer paths
package frc_pkg;
	// buffer gain selection
	typedef enum logic [1:0] {
		FRC_GAIN_OFF_E = 2'h0,
		FRC_GAIN_X1_E = 2'h1,
		FRC_GAIN_X2_E = 2'h2,
		FRC_GAIN_X4_E = 2'h3
	} frc_gain_t;
	// reference startup states, gray along off-wait-ready
	typedef enum logic [1:0] {
		FRC_ST_OFF = 2'h0,
		FRC_ST_WAIT = 2'h1,
		FRC_ST_READY = 2'h3
	} frc_state_t;
endpackage

// ===== frc_settle_timer.sv
// Purpose: down-counter that flags a buffer settle window as done
// Assumes: restart pulse on the pclk domain
// Notes: done is a register, low while counting
module frc_settle_timer #(
	parameter int unsigned CYCLES = 750
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	output logic done
);
	import frc_pkg::*;
	logic [15:0] cnt_q; // cycles left
	// reload on restart, count down to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
		end else if (restart) begin
			cnt_q <= CYCLES[15:0];
		end else if (cnt_q != 16'h0000) begin
			cnt_q <= cnt_q - 16'h0001;
		end
	end
	// done when no cycles left and no restart pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done <= 1'b1;
		end else begin
			done <= !restart && (cnt_q <= 16'h0001);
		end
	end
endmodule

// ===== frc_analog_model.sv
// Purpose: behavioural analog side, reports when reference has settled
// Assumes: settle time given as pclk cycles
// Notes: stable level drops at once when the enable goes away
module frc_analog_model #(
	parameter int unsigned DELAY = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reference_enable,
	output logic analog_stable
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt_q; // cycles since enable rose
	// settle counter, restarts whenever the reference is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			analog_stable <= 1'b0;
		end else if (!reference_enable) begin
			cnt_q <= 0;
			analog_stable <= 1'b0;
		end else if (cnt_q == DELAY) begin
			analog_stable <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule

// ===== fixed_reference_control_tb.sv
// Purpose: self-checking bench for the reference control register bank
// Assumes: zero-wait apb slave, analog model settles in 20 cycles
// Notes: status word holds ready in bit0, buffers settled in bit1
module fixed_reference_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import frc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdv;
	logic [31:0] prdata_hv, rdv_hv; // high-voltage variant read path
	logic pready, pslverr, stable, ref_en, ts_en, ts_rng, cmp_on, cnv_on, t2c, settled, errv;
	frc_gain_t cmp_g, cnv_g;
	logic [4:0] tch;
	int miscompares = 0, checks_done = 0, cycles = 0;
	always #20 pclk = ~pclk;
	frc_ctrl frc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .analog_stable(stable), .reference_enable(ref_en),
		.temp_sense_enable(ts_en), .temp_range_select(ts_rng), .comparator_path_gain(cmp_g),
		.converter_path_gain(cnv_g), .comparator_buf_on(cmp_on), .converter_buf_on(cnv_on),
		.temp_to_converter(t2c), .temp_channel(tch), .buffers_settled(settled));
	frc_analog_model frc_analog_model_inst (.pclk(pclk), .presetn(presetn),
		.reference_enable(ref_en), .analog_stable(stable));
	// high-voltage variant on the same bus, only its read data is used
	frc_ctrl #(.HIGH_VOLTAGE(1'b1)) frc_ctrl_hv_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_hv), .pready(), .pslverr(), .analog_stable(stable),
		.reference_enable(), .temp_sense_enable(), .temp_range_select(),
		.comparator_path_gain(), .converter_path_gain(), .comparator_buf_on(),
		.converter_buf_on(), .temp_to_converter(), .temp_channel(), .buffers_settled());
	// one comparison, reported at once on mismatch
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// apb transfer: setup, then access held until pready
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		rdv_hv = prdata_hv;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		chk(rdv, exp);
	endtask
	task t_reset;
		rd(12'h000, 32'h00000000);
		chk(rdv_hv, 32'h00000040);
		$display("test reset values done");
	endtask
	task t_fields;
		apb(1'b1, 12'h000, 32'h0000007F);
		rd(12'h000, 32'h0000003F);
		repeat (5000) @(posedge pclk);
		chk({ref_en, ts_en, ts_rng, t2c}, 32'h7);
		chk({cmp_g, cnv_g}, 32'hF);
		chk(tch, 32'h1D);
		$display("test field layout done");
	endtask
	task t_ready;
		apb(1'b1, 12'h000, 32'h00000080);
		repeat (2) @(posedge pclk);
		chk(ref_en, 32'h1);
		rd(12'h000, 32'h00000080);
		for (int i = 0; i < 60 && rdv[6] !== 1'b1; i++) apb(1'b0, 12'h000, '0);
		chk(rdv, 32'h000000C0);
		apb(1'b1, 12'h000, 32'h00000000);
		rd(12'h000, 32'h00000000);
		chk(rdv_hv, 32'h00000040);
		$display("test ready flag done");
	endtask
	task t_gain;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h000, {28'h0, i[1:0], i[1:0]});
			repeat (2) @(posedge pclk);
			chk({cmp_g, cmp_on}, {i[1:0], i != 0});
			chk({cnv_g, cnv_on}, {i[1:0], i != 0});
			if (i == 1) begin
				rd(12'h004, 32'h00000000);
				chk(settled, 32'h0);
			end
		end
		repeat (700) @(posedge pclk);
		rd(12'h004, 32'h00000000);
		repeat (60) @(posedge pclk);
		rd(12'h004, 32'h00000002);
		$display("test gain decode done");
	endtask
	task t_unmapped;
		apb(1'b1, 12'h010, 32'h000000FF);
		chk(errv, 32'h1);
		rd(12'h010, 32'h00000000);
		rd(12'h000, 32'h0000000F);
		$display("test unmapped address done");
	endtask
	task t_midreset;
		apb(1'b1, 12'h000, 32'h000000BF);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, 32'h00000000);
		chk({ref_en, ts_en, cmp_g, cnv_g}, 32'h0);
		$display("test reset in mid-run done");
	endtask
	task end_sim;
		$display("checks=%0d mismatches=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// run-length guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_ready();
		t_gain();
		t_unmapped();
		t_midreset();
		end_sim();
	end
endmodule
